/* src/sqcp_pkg.sv */
// Purpose: shared constants and carriers of the sequencer clock and
//          power-good configuration block
// Assumes: 10 MHz system clock, registers reached by byte address
// Notes:   every offset, bit position, reset value and time is named here
package sqcp_pkg;

   // register byte addresses
   localparam logic [7:0] ADDR_GENERAL_CONFIGURATION = 8'h13;
   localparam logic [7:0] ADDR_CLOCK_SOURCE_CONTROL = 8'h14;
   localparam logic [7:0] ADDR_POWER_GOOD_CONTROL_ONE = 8'h15;
   localparam logic [7:0] ADDR_POWER_GOOD_CONTROL_TWO = 8'h16;

   // reset values
   localparam logic [7:0] RST_GENERAL_CONFIGURATION = 8'h06;
   localparam logic [7:0] RST_CLOCK_SOURCE_CONTROL = 8'h01;
   localparam logic [7:0] RST_POWER_GOOD_CONTROL_ONE = 8'h73;
   localparam logic [7:0] RST_POWER_GOOD_CONTROL_TWO = 8'h04;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // general configuration fields
   localparam int CFG_STARTUP_RANGE = 6;
   localparam int CFG_SHUTDOWN_RANGE = 5;
   localparam int CFG_EXT_CLOCK_PIN_FUNCTION = 4;
   localparam int CFG_EXT_CLOCK_PIN_PULLDOWN = 3;
   localparam int CFG_TRIGGER_PIN_PULLDOWN = 2;
   localparam int CFG_THERMAL_WARNING_THRESHOLD = 1;
   localparam int CFG_SPREAD_SWITCHING_ENABLE = 0;

   // clock source control fields
   localparam int CLK_PLL_ENABLE = 6;
   localparam int CLK_FREQ_MSB = 4;
   localparam int CLK_FREQ_LSB = 0;
   localparam logic [4:0] FREQ_CODE_LAST_VALID = 5'h17;
   localparam logic [5:0] FREQ_MHZ_NONE = 6'h00;

   // power good control one fields
   localparam int PG1_POLARITY = 7;
   localparam int PG1_OUTPUT_TYPE = 6;
   localparam int PG1_LINEAR_WINDOW = 5;
   localparam int PG1_BUCK_WINDOW = 4;
   localparam int PG1_MONITOR_MSB = 3;
   localparam int PG1_MONITOR_LSB = 0;

   // power good control two fields
   localparam int PG2_THERMAL_GATES = 2;
   localparam int PG2_LATCHED_FAULT_GATING = 1;
   localparam int PG2_OPERATING_MODE = 0;

   // rail indices: bucks low, linear rails high
   localparam int RAIL_COUNT = 4;
   localparam int RAIL_FIRST_LINEAR = 2;

   // delay timing
   localparam int CLOCK_PERIOD_NS = 100;
   localparam int DELAY_STEP_NS = 500_000;
   localparam int HALF_MS_CYCLES_DEFAULT = DELAY_STEP_NS / CLOCK_PERIOD_NS;
   localparam int PRESCALE_W = 13;
   localparam int DELAY_CODE_W = 4;
   localparam int DELAY_COUNT_W = 5;

   // per-rail delay codes
   typedef struct packed {
      logic [DELAY_CODE_W-1:0] shutdown_code;
      logic [DELAY_CODE_W-1:0] startup_code;
   } sqcp_delay_s;

   // inputs that arrive from outside the clock domain
   typedef struct packed {
      logic trigger;
      logic thermal_warning;
      logic ext_clock_detect;
      logic [RAIL_COUNT-1:0] undervoltage;
      logic [RAIL_COUNT-1:0] overvoltage;
   } sqcp_async_s;

   // one pin driven as output value plus enable
   typedef struct packed {
      logic value;
      logic enable;
   } sqcp_pin_s;

   // delay unit states, one-hot
   typedef enum logic [2:0] {
      DLY_IDLE = 3'h1,
      DLY_UP_WAIT = 3'h2,
      DLY_DOWN_WAIT = 3'h4
   } sqcp_delay_state_e;

endpackage : sqcp_pkg

/* src/sqcp_delay_unit.sv */
// Purpose: one rail's startup and shutdown delay timer
// Assumes: half-millisecond tick from the parent, trigger edges as pulses
// Notes:   a code of zero acts on the edge itself
`timescale 1ns/10ps
`default_nettype none
module sqcp_delay_unit
   import sqcp_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clock_en,
   input wire logic i_rise,
   input wire logic i_fall,
   input wire logic i_tick,
   input wire sqcp_delay_s i_codes,
   input wire logic i_startup_range,
   input wire logic i_shutdown_range,
   output logic o_on
);
   sqcp_delay_state_e state; // where the unit is in its sequence
   logic [DELAY_COUNT_W-1:0] remaining; // half-ms ticks left to wait
   logic [DELAY_COUNT_W-1:0] up_count; // startup wait in half-ms ticks
   logic [DELAY_COUNT_W-1:0] down_count; // shutdown wait in half-ms ticks

   // code times step
   // range 1 doubles the step, so the code is shifted into ticks
   assign up_count = i_startup_range ? {i_codes.startup_code, 1'b0}
                                     : {1'b0, i_codes.startup_code};
   assign down_count = i_shutdown_range ? {i_codes.shutdown_code, 1'b0}
                                        : {1'b0, i_codes.shutdown_code};

   // sequence: a new edge always restarts the wait
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state <= DLY_IDLE;
         remaining <= '0;
         o_on <= 1'b0;
      end else if (i_clock_en) begin
         if (i_rise) begin
            if (up_count == '0) begin
               o_on <= 1'b1;
               state <= DLY_IDLE;
            end else begin
               remaining <= up_count;
               state <= DLY_UP_WAIT;
            end
         end else if (i_fall) begin
            if (down_count == '0) begin
               o_on <= 1'b0;
               state <= DLY_IDLE;
            end else begin
               remaining <= down_count;
               state <= DLY_DOWN_WAIT;
            end
         end else begin
            case (state)
               DLY_UP_WAIT: begin
                  if (i_tick) begin
                     remaining <= remaining - 1'b1;
                     if (remaining == 5'h01) begin
                        o_on <= 1'b1;
                        state <= DLY_IDLE;
                     end
                  end
               end
               DLY_DOWN_WAIT: begin
                  if (i_tick) begin
                     remaining <= remaining - 1'b1;
                     if (remaining == 5'h01) begin
                        o_on <= 1'b0;
                        state <= DLY_IDLE;
                     end
                  end
               end
               default: begin
                  // idle holds the output
                  state <= DLY_IDLE;
               end
            endcase
         end
      end
   end

endmodule : sqcp_delay_unit
`default_nettype wire

/* src/sqcp_config_top.sv */
// Purpose: configuration registers of the sequencer, clock source and
//          power-good output, with the delay timing and power-good logic
// Assumes: register port is the decoded side of the serial interface
// Notes:   read data appears one cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
module sqcp_config_top
   import sqcp_pkg::*;
#(
   parameter int HALF_MS_CYCLES = HALF_MS_CYCLES_DEFAULT
)
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clock_en,
   // register port
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_write,
   input wire logic i_reg_read,
   output logic [7:0] o_reg_rdata,
   // asynchronous inputs from pins and analog comparators
   input wire sqcp_async_s i_async,
   // per-rail delay codes and latched faults from neighbour registers
   input wire sqcp_delay_s [RAIL_COUNT-1:0] i_delay_codes,
   input wire logic [RAIL_COUNT-1:0] i_rail_fault_latch,
   input wire logic i_general_output_two_level,
   // external clock pin, four signals
   input wire logic i_ext_clock_pin_in,
   output logic o_ext_clock_pin_out,
   output logic o_ext_clock_pin_oe,
   output logic o_ext_clock_pin_sample,
   // configuration outputs towards the analog side
   output logic o_ext_clock_pin_pulldown,
   output logic o_trigger_pin_pulldown,
   output logic o_thermal_warning_threshold,
   output logic o_spread_switching_enable,
   output logic o_pll_enable,
   output logic o_use_ext_clock,
   output logic [4:0] o_ext_clock_frequency_code,
   output logic [5:0] o_ext_clock_freq_mhz,
   output logic o_clock_change_event,
   output logic [RAIL_COUNT-1:0] o_rail_enable,
   // power-good pin, three signals
   output logic o_power_good_output,
   output logic o_power_good_oe,
   output logic o_power_good_level
);
   // registers
   logic [7:0] general_configuration; // range, pin and thermal options
   logic [7:0] clock_source_control; // pll and frequency code
   logic [7:0] power_good_control_one; // polarity, type, windows
   logic [7:0] power_good_control_two; // gating and mode

   // synchroniser chain for the asynchronous inputs
   sqcp_async_s sync_one; // first stage, only feeds the second
   sqcp_async_s sync_two; // second stage
   sqcp_async_s sync_three; // third stage
   sqcp_async_s sampled; // accepted value once stages two and three agree

   // trigger edges and time base
   logic trigger_prev; // last accepted trigger level
   logic trigger_rise; // accepted trigger went high
   logic trigger_fall; // accepted trigger went low
   logic [PRESCALE_W-1:0] prescale; // cycles inside one half-ms step
   logic half_ms_tick; // one-cycle pulse per half millisecond

   // clock source and power-good working signals
   logic detect_prev; // last accepted clock-detect level
   logic [RAIL_COUNT-1:0] rail_valid; // rail passes its window check
   logic [RAIL_COUNT-1:0] window_sel; // overvoltage check per rail
   logic [RAIL_COUNT-1:0] monitor_en; // rails included in power-good
   logic live_good; // all monitored rails valid now
   logic next_good; // power-good before polarity
   logic pin_level; // power-good pin level after polarity
   logic freq_code_valid; // code inside the defined range

   // synchroniser: three flops per async input
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         sync_one <= '0;
         sync_two <= '0;
         sync_three <= '0;
      end else if (i_clock_en) begin
         sync_one <= i_async;
         sync_two <= sync_one;
         sync_three <= sync_two;
      end
   end

   // accept each bit only when stages two and three agree
   genvar gb;
   generate
      for (gb = 0; gb < $bits(sqcp_async_s); gb++) begin : g_accept
         always_ff @(posedge i_clock) begin
            if (i_rst) begin
               sampled[gb] <= 1'b0;
            end else if (i_clock_en && (sync_two[gb] == sync_three[gb])) begin
               sampled[gb] <= sync_three[gb];
            end
         end
      end
   endgenerate

   // register writes; every bit stores what was written
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         general_configuration <= RST_GENERAL_CONFIGURATION;
         clock_source_control <= RST_CLOCK_SOURCE_CONTROL;
         power_good_control_one <= RST_POWER_GOOD_CONTROL_ONE;
         power_good_control_two <= RST_POWER_GOOD_CONTROL_TWO;
      end else if (i_clock_en && i_reg_write) begin
         case (i_reg_addr)
            ADDR_GENERAL_CONFIGURATION: begin
               general_configuration <= i_reg_wdata;
            end
            ADDR_CLOCK_SOURCE_CONTROL: begin
               // reserved bit stored
               // a nonzero reserved bit is kept but steers nothing
               clock_source_control <= i_reg_wdata;
            end
            ADDR_POWER_GOOD_CONTROL_ONE: begin
               power_good_control_one <= i_reg_wdata;
            end
            ADDR_POWER_GOOD_CONTROL_TWO: begin
               power_good_control_two <= i_reg_wdata;
            end
            default: begin
               // unmapped writes are dropped
            end
         endcase
      end
   end

   // register reads, registered one cycle after the strobe
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_reg_rdata <= READ_UNMAPPED;
      end else if (i_clock_en && i_reg_read) begin
         case (i_reg_addr)
            ADDR_GENERAL_CONFIGURATION: begin
               o_reg_rdata <= general_configuration;
            end
            ADDR_CLOCK_SOURCE_CONTROL: begin
               o_reg_rdata <= clock_source_control;
            end
            ADDR_POWER_GOOD_CONTROL_ONE: begin
               o_reg_rdata <= power_good_control_one;
            end
            ADDR_POWER_GOOD_CONTROL_TWO: begin
               o_reg_rdata <= power_good_control_two;
            end
            default: begin
               o_reg_rdata <= READ_UNMAPPED;
            end
         endcase
      end
   end

   // trigger edge detect on the accepted level
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         trigger_prev <= 1'b0;
      end else if (i_clock_en) begin
         trigger_prev <= sampled.trigger;
      end
   end
   assign trigger_rise = sampled.trigger & ~trigger_prev;
   assign trigger_fall = ~sampled.trigger & trigger_prev;

   // timed from trigger edge
   // restarting the prescaler on each edge keeps the first step whole
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         prescale <= '0;
      end else if (i_clock_en) begin
         if (trigger_rise || trigger_fall || half_ms_tick) begin
            prescale <= '0;
         end else begin
            prescale <= prescale + 1'b1;
         end
      end
   end
   assign half_ms_tick =
      (prescale == PRESCALE_W'(HALF_MS_CYCLES - 1));

   // one delay timer per rail
   genvar gr;
   generate
      for (gr = 0; gr < RAIL_COUNT; gr++) begin : g_rail
         sqcp_delay_unit u_delay (
            .i_clock(i_clock),
            .i_rst(i_rst),
            .i_clock_en(i_clock_en),
            .i_rise(trigger_rise),
            .i_fall(trigger_fall),
            .i_tick(half_ms_tick),
            .i_codes(i_delay_codes[gr]),
            .i_startup_range(general_configuration[CFG_STARTUP_RANGE]),
            .i_shutdown_range(general_configuration[CFG_SHUTDOWN_RANGE]),
            .o_on(o_rail_enable[gr])
         );
      end
   endgenerate

   // configuration outputs that need no logic beyond a flop
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_ext_clock_pin_pulldown <= 1'b0;
         o_trigger_pin_pulldown <= 1'b1;
         o_thermal_warning_threshold <= 1'b1;
         o_spread_switching_enable <= 1'b0;
      end else if (i_clock_en) begin
         o_ext_clock_pin_pulldown <=
            general_configuration[CFG_EXT_CLOCK_PIN_PULLDOWN];
         o_trigger_pin_pulldown <=
            general_configuration[CFG_TRIGGER_PIN_PULLDOWN];
         o_thermal_warning_threshold <=
            general_configuration[CFG_THERMAL_WARNING_THRESHOLD];
         o_spread_switching_enable <=
            general_configuration[CFG_SPREAD_SWITCHING_ENABLE];
      end
   end

   // external clock pin: general output or clock input
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_ext_clock_pin_out <= 1'b0;
         o_ext_clock_pin_oe <= 1'b0;
      end else if (i_clock_en) begin
         if (general_configuration[CFG_EXT_CLOCK_PIN_FUNCTION]) begin
            o_ext_clock_pin_out <= 1'b0;
            o_ext_clock_pin_oe <= 1'b0;
         end else begin
            o_ext_clock_pin_out <= i_general_output_two_level;
            o_ext_clock_pin_oe <= 1'b1;
         end
      end
   end
   // the raw pin goes straight to the pll; it is far too fast to sample
   assign o_ext_clock_pin_sample = i_ext_clock_pin_in;

   // frequency code decode
   // code plus one MHz
   assign freq_code_valid =
      (clock_source_control[CLK_FREQ_MSB:CLK_FREQ_LSB]
       <= FREQ_CODE_LAST_VALID);

   // clock source selection and change events
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_pll_enable <= 1'b0;
         o_use_ext_clock <= 1'b0;
         o_ext_clock_frequency_code <= RST_CLOCK_SOURCE_CONTROL[4:0];
         o_ext_clock_freq_mhz <= FREQ_MHZ_NONE;
         o_clock_change_event <= 1'b0;
         detect_prev <= 1'b0;
      end else if (i_clock_en) begin
         detect_prev <= sampled.ext_clock_detect;
         o_pll_enable <= clock_source_control[CLK_PLL_ENABLE];
         o_ext_clock_frequency_code <=
            clock_source_control[CLK_FREQ_MSB:CLK_FREQ_LSB];
         // reserved codes report no frequency rather than a wrong one
         o_ext_clock_freq_mhz <= freq_code_valid
            ? {1'b0, clock_source_control[CLK_FREQ_MSB:CLK_FREQ_LSB]}
              + 6'h01
            : FREQ_MHZ_NONE;
         if (!clock_source_control[CLK_PLL_ENABLE]) begin
            o_use_ext_clock <= 1'b0;
            o_clock_change_event <= 1'b0;
         end else begin
            o_use_ext_clock <= sampled.ext_clock_detect &
               general_configuration[CFG_EXT_CLOCK_PIN_FUNCTION];
            o_clock_change_event <= sampled.ext_clock_detect ^ detect_prev;
         end
      end
   end

   // window selection and monitored set per rail
   // per-rail monitor enables
   assign monitor_en =
      power_good_control_one[PG1_MONITOR_MSB:PG1_MONITOR_LSB];

   genvar gw;
   generate
      for (gw = 0; gw < RAIL_COUNT; gw++) begin : g_window
         if (gw >= RAIL_FIRST_LINEAR) begin : g_linear
            assign window_sel[gw] = power_good_control_one[PG1_LINEAR_WINDOW];
         end else begin : g_buck
            assign window_sel[gw] = power_good_control_one[PG1_BUCK_WINDOW];
         end
         assign rail_valid[gw] = ~sampled.undervoltage[gw] &
            ~(window_sel[gw] & sampled.overvoltage[gw]);
      end
   endgenerate

   // excluded rails count as valid
   assign live_good = &(rail_valid | ~monitor_en);

   // power-good decision before polarity
   always_comb begin
      if (power_good_control_two[PG2_LATCHED_FAULT_GATING]) begin
         next_good = ~|i_rail_fault_latch;
      end else begin
         next_good = live_good;
      end
      if (power_good_control_two[PG2_THERMAL_GATES] &&
          sampled.thermal_warning) begin
         next_good = 1'b0;
      end
      // gated or continuous
      // gated mode only reports good while the sequence is enabled
      if (!power_good_control_two[PG2_OPERATING_MODE] &&
          !sampled.trigger) begin
         next_good = 1'b0;
      end
   end

   assign pin_level = next_good ^ power_good_control_one[PG1_POLARITY];

   // power-good pin drive
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_power_good_level <= 1'b0;
         o_power_good_output <= 1'b0;
         o_power_good_oe <= 1'b1;
      end else if (i_clock_en) begin
         o_power_good_level <= pin_level;
         if (power_good_control_one[PG1_OUTPUT_TYPE]) begin
            // open drain only pulls low, high comes from the pull-up
            o_power_good_output <= 1'b0;
            o_power_good_oe <= ~pin_level;
         end else begin
            o_power_good_output <= pin_level;
            o_power_good_oe <= 1'b1;
         end
      end
   end

endmodule : sqcp_config_top
`default_nettype wire

/* tb/sqcp_config_sva.sv */
// Purpose: port checks of the configuration block
// Assumes: one clock, synchronous reset
// Notes: bound into every instance of the top
`timescale 1ns/10ps
`default_nettype none
module sqcp_config_sva
   import sqcp_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clock_en,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_write,
   input wire logic i_reg_read,
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_ext_clock_pin_oe,
   input wire logic o_trigger_pin_pulldown,
   input wire logic o_pll_enable,
   input wire logic o_use_ext_clock,
   input wire logic [4:0] o_ext_clock_frequency_code,
   input wire logic [5:0] o_ext_clock_freq_mhz,
   input wire logic o_clock_change_event,
   input wire logic o_power_good_output,
   input wire logic o_power_good_oe,
   input wire logic o_power_good_level
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // write taken, then one more enabled edge for the output copy
   sequence s_wr(a);
      i_clock_en && i_reg_write && i_reg_addr == a ##1 i_clock_en;
   endsequence
   a_trig_pd_copy: assert property (
      s_wr(ADDR_GENERAL_CONFIGURATION) |=> o_trigger_pin_pulldown ==
      $past(i_reg_wdata[CFG_TRIGGER_PIN_PULLDOWN], 2)) else $error("pd");
   a_pin_fn_copy: assert property (
      s_wr(ADDR_GENERAL_CONFIGURATION) |=> o_ext_clock_pin_oe ==
      !$past(i_reg_wdata[CFG_EXT_CLOCK_PIN_FUNCTION], 2)) else $error("oe");
   a_pll_en_copy: assert property (
      s_wr(ADDR_CLOCK_SOURCE_CONTROL) |=> o_pll_enable ==
      $past(i_reg_wdata[CLK_PLL_ENABLE], 2)) else $error("pll enable");
   a_read_back: assert property (
      s_wr(ADDR_GENERAL_CONFIGURATION) ##0 i_reg_read && i_reg_addr ==
      ADDR_GENERAL_CONFIGURATION |=> o_reg_rdata == $past(i_reg_wdata, 2))
      else $error("read back");
   a_unmapped_zero: assert property (
      i_clock_en && i_reg_read && (i_reg_addr < ADDR_GENERAL_CONFIGURATION
      || i_reg_addr > ADDR_POWER_GOOD_CONTROL_TWO) |=> o_reg_rdata ==
      READ_UNMAPPED) else $error("unmapped read");
   // the frequency resets to none while the code resets to 1, so wait for a settled code
   a_freq_mhz_map: assert property (
      (i_clock_en && $stable(o_ext_clock_frequency_code)) [*2] |->
      o_ext_clock_freq_mhz == ((o_ext_clock_frequency_code <= 5'h17) ?
      {1'b0, o_ext_clock_frequency_code} + 6'h01 : 6'h00))
      else $error("frequency");
   a_pg_release: assert property (
      !o_power_good_oe |-> o_power_good_level && !o_power_good_output)
      else $error("open drain");
   a_pg_drive: assert property (
      o_power_good_output |-> o_power_good_oe && o_power_good_level)
      else $error("power good level");
   a_event_pulse: assert property (
      o_clock_change_event |=> !o_clock_change_event) else $error("event");
   a_ext_needs_pll: assert property (
      o_use_ext_clock |-> o_pll_enable) else $error("ext clock use");
endmodule : sqcp_config_sva
bind sqcp_config_top sqcp_config_sva u_sqcp_config_sva (.i_clock, .i_rst,
   .i_clock_en, .i_reg_addr, .i_reg_wdata, .i_reg_write, .i_reg_read,
   .o_reg_rdata, .o_ext_clock_pin_oe, .o_trigger_pin_pulldown, .o_pll_enable,
   .o_use_ext_clock, .o_ext_clock_frequency_code, .o_ext_clock_freq_mhz,
   .o_clock_change_event, .o_power_good_output, .o_power_good_oe,
   .o_power_good_level);
`default_nettype wire

/* tb/sqcp_host.sv */
// Purpose: host side of the register port
// Assumes: tasks entered just after a rising edge
// Notes: callers leave one edge between two strobes of one kind
`timescale 1ns/10ps
`default_nettype none
module sqcp_host
   import sqcp_pkg::*;
(
   input wire logic i_clock,
   output logic [7:0] o_addr = 8'h00,
   output logic [7:0] o_wdata = 8'h00,
   output logic o_write = 1'b0,
   output logic o_read = 1'b0,
   input wire logic [7:0] i_rdata
);
   // reserved clock bits sent as zero
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      o_addr = a;
      o_wdata = (a == ADDR_CLOCK_SOURCE_CONTROL) ? (d & 8'h5F) : d;
      o_write = 1'b1;
      @(posedge i_clock);
      #1;
      o_write = 1'b0;
   endtask : wr
   // data is registered on the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      o_addr = a;
      o_read = 1'b1;
      @(posedge i_clock);
      #1;
      o_read = 1'b0;
      d = i_rdata;
   endtask : rd
endmodule : sqcp_host
`default_nettype wire

/* tb/tb.sv */
// Purpose: self-checking bench of the configuration block
// Assumes: half-ms count shortened to ten cycles
// Notes: each scenario task drives and judges
`timescale 1ns/10ps
`default_nettype none
module tb
   import sqcp_pkg::*;
;
   localparam int HALF = 10;
   logic i_clock;
   logic i_rst = 1'b1;
   sqcp_async_s i_async = '0;
   sqcp_delay_s [3:0] i_delay_codes = {4{8'h02}};
   logic [3:0] i_rail_fault_latch = 4'h0;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
   logic i_reg_write, i_reg_read, o_ext_clock_pin_oe, o_pll_enable;
   logic o_ext_clock_pin_pulldown, o_trigger_pin_pulldown, o_use_ext_clock;
   logic o_thermal_warning_threshold, o_spread_switching_enable;
   logic o_clock_change_event, o_power_good_output, o_power_good_oe;
   logic o_power_good_level, o_ext_clock_pin_out;
   logic [4:0] o_ext_clock_frequency_code;
   logic [5:0] o_ext_clock_freq_mhz;
   logic [3:0] o_rail_enable;
   int n_fail = 0;
   int cmp_count = 0;
   int n0, n1, e;
   // config outputs packed for one compare
   wire logic [5:0] cfg_out = {o_ext_clock_pin_oe, o_ext_clock_pin_pulldown,
      o_trigger_pin_pulldown, o_thermal_warning_threshold,
      o_spread_switching_enable, o_pll_enable};
   sqcp_host u_sqcp_host (.i_clock, .o_addr(i_reg_addr),
      .o_wdata(i_reg_wdata), .o_write(i_reg_write), .o_read(i_reg_read),
      .i_rdata(o_reg_rdata));
   sqcp_config_top #(.HALF_MS_CYCLES(HALF)) u_sqcp_config_top (.i_clock,
      .i_rst, .i_clock_en(1'b1), .i_reg_addr, .i_reg_wdata, .i_reg_write,
      .i_reg_read, .o_reg_rdata, .i_async, .i_delay_codes,
      .i_rail_fault_latch, .i_general_output_two_level(i_async.trigger),
      .i_ext_clock_pin_in(1'b0), .o_ext_clock_pin_out, .o_ext_clock_pin_oe,
      .o_ext_clock_pin_sample(), .o_ext_clock_pin_pulldown,
      .o_trigger_pin_pulldown, .o_thermal_warning_threshold,
      .o_spread_switching_enable, .o_pll_enable, .o_use_ext_clock,
      .o_ext_clock_frequency_code, .o_ext_clock_freq_mhz,
      .o_clock_change_event, .o_rail_enable, .o_power_good_output,
      .o_power_good_oe, .o_power_good_level);
   initial begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end
   task automatic step(input int n);
      repeat (n) begin
         @(posedge i_clock);
         #1;
      end
   endtask : step
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test
   task automatic t_reset();
      logic [7:0] d;
      logic [7:0] rv [4] = '{8'h06, 8'h01, 8'h73, 8'h04};
      foreach (rv[i]) begin
         u_sqcp_host.rd(8'h13 + 8'(i), d);
         chk(d, rv[i]);
         step(1);
      end
      u_sqcp_host.rd(8'h17, d);
      chk(d, 8'h00);
      chk({2'b00, cfg_out}, 8'h2C);
   endtask : t_reset
   task automatic t_cfg();
      logic [7:0] d;
      u_sqcp_host.wr(8'h13, 8'h19);
      u_sqcp_host.rd(8'h13, d);
      chk(d, 8'h19);
      chk({2'b00, cfg_out}, 8'h12);
      u_sqcp_host.wr(8'h13, 8'h0E);
      step(1);
      chk({2'b00, cfg_out}, 8'h3C);
   endtask : t_cfg
   // pulses seen over ten cycles, a pulse stands one cycle
   task automatic count_ev(output int n);
      n = 0;
      repeat (10) begin
         step(1);
         n += int'(o_clock_change_event);
      end
   endtask : count_ev
   task automatic t_clock();
      logic [4:0] c [3] = '{5'h00, 5'h0A, 5'h17};
      foreach (c[i]) begin
         u_sqcp_host.wr(8'h14, {3'b010, c[i]});
         step(3);
         chk({2'b00, o_ext_clock_freq_mhz}, 8'(c[i]) + 8'h01);
      end
      u_sqcp_host.wr(8'h13, 8'h16);
      i_async.ext_clock_detect = 1'b1;
      count_ev(e);
      chk(8'(e), 8'h01);
      chk({7'h00, o_use_ext_clock}, 8'h01);
      i_async.ext_clock_detect = 1'b0;
      count_ev(e);
      chk(8'(e), 8'h01);
      u_sqcp_host.wr(8'h14, 8'h01);
      i_async.ext_clock_detect = 1'b1;
      count_ev(e);
      chk({o_use_ext_clock, 7'(e)}, 8'h00);
   endtask : t_clock
   // cycles from trigger rise until every rail is on
   task automatic t_delay(input logic sel, output int n);
      u_sqcp_host.wr(8'h13, {1'b0, sel, 6'h06});
      i_async.trigger = 1'b1;
      for (n = 0; n < 300 && o_rail_enable !== 4'hF; n++) begin
         step(1);
      end
      if (n == 300) begin
         n_fail++;
         stop_test();
      end
      chk({7'h00, o_ext_clock_pin_out}, 8'h01);
      i_async.trigger = 1'b0;
      step(8);
      chk({4'h0, o_rail_enable}, 8'h00);
   endtask : t_delay
   // write one register, then judge level, enable and pin value
   task automatic pg(input logic [7:0] a, d, input logic [2:0] x);
      u_sqcp_host.wr(a, d);
      step(8);
      chk({o_power_good_level, o_power_good_oe, o_power_good_output}, x);
   endtask : pg
   initial begin
      step(4);
      i_rst = 1'b0;
      t_reset();
      t_cfg();
      t_clock();
      t_delay(1'b0, n0);
      t_delay(1'b1, n1);
      chk(8'(n1 - n0), 8'(2 * HALF));
      pg(8'h15, 8'h33, 3'b010);
      pg(8'h16, 8'h05, 3'b111);
      i_async.thermal_warning = 1'b1;
      pg(8'h16, 8'h05, 3'b010);
      pg(8'h16, 8'h01, 3'b111);
      pg(8'h15, 8'hF3, 3'b010);
      i_rail_fault_latch = 4'h1;
      pg(8'h16, 8'h03, 3'b100);
      i_async.overvoltage = 4'h1;
      pg(8'h16, 8'h01, 3'b100);
      pg(8'h15, 8'hE3, 3'b010);
      stop_test();
   end
endmodule : tb
`default_nettype wire
